//--- pkg/fifo_pkg.sv
// Shared constants for the dual-mode FIFO: register map, field positions,
// reset values and flag pipeline depths.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package fifo_pkg;

  // Default geometry
  localparam int DATA_W = 36;
  localparam int FIFO_DEPTH = 1024;

  // Offset value loaded into both flag offsets at reset
  localparam int DEF_OFFSET = 127;

  // Register byte offsets
  localparam logic [3:0] OFS_EMPTY_OFFSET = 4'h0;
  localparam logic [3:0] OFS_FULL_OFFSET = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_LEVEL = 4'hc;

  // Status register field positions
  localparam int ST_MODE = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_HALF = 3;
  localparam int ST_ALMOST_FULL = 4;
  localparam int ST_ALMOST_EMPTY = 5;

  // Register stages in front of the flag pins, in cycles
  localparam int FLAG_SYNC_STAGES = 2;
  localparam int VALID_STAGES = 3;
  localparam int PTR_SYNC_STAGES = 2;

  // Values after reset
  localparam logic RST_MODE = 1'b0;
  localparam logic [31:0] RST_READDATA = 32'h0;

endpackage : fifo_pkg

//--- pkg/fifo_mem_if.sv
// Connection between the FIFO control logic and its storage array.
// Assumes one clock shared by both ends.
interface fifo_mem_if #(
  parameter int AW = 10,
  parameter int DW = 36
) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr,
    input rd_data
  );
  modport mem (
    input wr_en, wr_addr, wr_data, rd_en, rd_addr,
    output rd_data
  );
endinterface : fifo_mem_if

//--- design/fifo_mem.sv
// Simple dual-port storage with a registered read port.
// Assumes the controller never reads and writes one address in one cycle
// when it needs the new word; read data update only on rd_en.
module fifo_mem #(
  parameter int AW = 10,
  parameter int DW = 36
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Storage port
  fifo_mem_if.mem m
);

  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rd_data_ff;

  // No reset on the array so it maps onto block memory
  always_ff @(posedge clk) begin
    if (m.wr_en) begin
      store[m.wr_addr] <= m.wr_data;
    end
  end

  // The read register doubles as the output register of the FIFO
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else if (m.rd_en) begin
      rd_data_ff <= store[m.rd_addr];
    end
  end

  assign m.rd_data = rd_data_ff;

endmodule : fifo_mem

//--- design/dual_mode_fifo.sv
// Dual-mode synchronous FIFO with status flags and an Avalon-MM slave for
// flag offsets, status and fill level.
// Assumes writer and reader are logic on CLK; only the mode pin is async.
//
// Summary of operation
// - Mode pin sampled during reset; low standard, high fall-through.
// - Fall-through: first word reaches outputs three edges after writing.
// - Word captured on each clock edge while write enable is low.
// - Standard: empty flag goes high after first write.
// - Standard: almost-empty flag rises at n+1 stored words.
// - Standard: half-full flag falls at D/2+1 words.
// - Standard: almost-full flag falls at D-m words.
// - Standard: full flag falls after D words; writes then blocked.
// - Standard: reads release full, then almost-full and half-full.
// - Standard: almost-empty falls when n words remain.
// - Standard: empty flag falls on last read; reads ignored while empty.
// - Standard: empty and full flags pass two register stages.
// - Fall-through: valid low after first write; almost-empty up at n+2.
// - Fall-through: half-full falls at D/2+2 words incl. output register.
// - Fall-through: almost-full falls at D+1-m words.
// - Fall-through: capacity D+1; input-ready goes high when full.
// - Fall-through: first read from full drives input-ready low.
// - Fall-through: almost-empty falls when n+1 words remain.
// - Fall-through: valid high after last read; reads then ignored.
// - Fall-through: valid passes three stages, input-ready two.
// - Empty and full offsets limited to 0 through D-1.
module dual_mode_fifo
  import fifo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int WIDTH = DATA_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Mode strap
  input wire logic FALL_THROUGH_SELECT,
  // Write side
  input wire logic WRITE_EN_N,
  input wire logic [WIDTH-1:0] DATA_IN,
  // Read side
  input wire logic READ_EN_N,
  output logic [WIDTH-1:0] READ_DATA_OUT,
  // Flags
  output logic EMPTY_FLAG_N,
  output logic FULL_FLAG_N,
  output logic OUTPUT_VALID_N,
  output logic INPUT_READY_N,
  output logic ALMOST_EMPTY_FLAG_N,
  output logic ALMOST_FULL_FLAG_N,
  output logic HALF_FULL_FLAG_N,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int CW = AW + 2;
  // A shallow FIFO cannot hold the default offset, so it is clipped to D-1
  localparam int DEF_OFS = (DEF_OFFSET < DEPTH) ? DEF_OFFSET : DEPTH - 1;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes

  // Mode strap: synchronised, then caught at the first edge after release
  logic [1:0] sel_sync;
  logic fall_through_timing_ff;
  logic init_ff;

  always_ff @(posedge CLK) begin
    sel_sync <= {sel_sync[0], FALL_THROUGH_SELECT};
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fall_through_timing_ff <= RST_MODE;
      init_ff <= 1'b1;
    end else if (init_ff) begin
      fall_through_timing_ff <= sel_sync[1];
      init_ff <= 1'b0;
    end
  end

  // Pointers, held both binary and gray
  logic [PW-1:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
  logic [PTR_SYNC_STAGES-1:0][PW-1:0] wg_sync_ff, rg_sync_ff;
  logic [PTR_SYNC_STAGES-1:0] ov_ws_ff;
  logic ov_ff;

  fifo_mem_if #(.AW(AW), .DW(WIDTH)) mif ();

  // Write side, working from the read pointer seen through its sync
  wire [PW-1:0] rsync_bin = gray2bin(rg_sync_ff[PTR_SYNC_STAGES-1]);
  wire [PW-1:0] wcount = wbin_ff - rsync_bin;
  // The memory holds D; the output register adds one more in fall-through
  wire full_w = (wcount == PW'(DEPTH));
  wire wr_acc = !WRITE_EN_N && !full_w && !init_ff;
  wire [PW-1:0] nxt_wbin = wbin_ff + PW'(1);
  wire [CW-1:0] mode_add = CW'(fall_through_timing_ff);
  wire [CW-1:0] tot_w = CW'(wcount) + CW'(fall_through_timing_ff & ov_ws_ff[1]);

  // Read side, working from the write pointer seen through its sync
  wire [PW-1:0] wsync_bin = gray2bin(wg_sync_ff[PTR_SYNC_STAGES-1]);
  wire [PW-1:0] rcount = wsync_bin - rbin_ff;
  wire rnz = (rcount != '0);
  wire pop = !READ_EN_N && ov_ff;
  // Standard mode fetches only on request; fall-through refills itself
  wire rd_issue = fall_through_timing_ff ? (rnz && (!ov_ff || pop))
                          : (!READ_EN_N && rnz);
  wire nxt_ov = fall_through_timing_ff && (rd_issue || (ov_ff && !pop));
  wire [PW-1:0] nxt_rbin = rbin_ff + PW'(1);
  wire [CW-1:0] tot_r = CW'(rcount) + CW'(fall_through_timing_ff & ov_ff);

  // Flag offsets
  logic [AW-1:0] empty_off_ff, full_off_ff;

  // Thresholds move up by one word in fall-through for the output register
  wire [CW-1:0] hf_thr = CW'(DEPTH / 2 + 1) + mode_add;
  wire [CW-1:0] paf_thr = CW'(DEPTH) - CW'(full_off_ff) + mode_add;
  wire [CW-1:0] pae_thr = CW'(empty_off_ff) + CW'(1) + mode_add;
  wire hf_hit = (tot_w >= hf_thr);
  wire paf_hit = (tot_w >= paf_thr);
  wire pae_hit = (tot_r >= pae_thr);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wbin_ff <= '0;
      wgray_ff <= '0;
    end else if (wr_acc) begin
      wbin_ff <= nxt_wbin;
      wgray_ff <= bin2gray(nxt_wbin);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rbin_ff <= '0;
      rgray_ff <= '0;
      ov_ff <= 1'b0;
    end else begin
      ov_ff <= nxt_ov;
      if (rd_issue) begin
        rbin_ff <= nxt_rbin;
        rgray_ff <= bin2gray(nxt_rbin);
      end
    end
  end

  // Gray pointers change one bit a step, so each stage sees a legal value
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wg_sync_ff <= '0;
      rg_sync_ff <= '0;
      ov_ws_ff <= '0;
    end else begin
      wg_sync_ff <= {wg_sync_ff[PTR_SYNC_STAGES-2:0], wgray_ff};
      rg_sync_ff <= {rg_sync_ff[PTR_SYNC_STAGES-2:0], rgray_ff};
      ov_ws_ff <= {ov_ws_ff[PTR_SYNC_STAGES-2:0], ov_ff};
    end
  end

  assign mif.wr_en = wr_acc;
  assign mif.wr_addr = wbin_ff[AW-1:0];
  assign mif.wr_data = DATA_IN;
  assign mif.rd_en = rd_issue;
  assign mif.rd_addr = rbin_ff[AW-1:0];
  assign READ_DATA_OUT = mif.rd_data;

  fifo_mem #(.AW(AW), .DW(WIDTH)) u_mem (
    .clk(CLK),
    .rst(RST),
    .m(mif)
  );

  // Flag pipelines in front of the pins
  logic [FLAG_SYNC_STAGES-1:0] full_chain_ff, nempty_chain_ff;
  logic [VALID_STAGES-1:0] ov_chain_ff;
  logic hf_n_ff, paf_n_ff, pae_n_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      full_chain_ff <= '0;
      nempty_chain_ff <= '0;
      ov_chain_ff <= '0;
      hf_n_ff <= 1'b1;
      paf_n_ff <= 1'b1;
      pae_n_ff <= 1'b0;
    end else begin
      full_chain_ff <= {full_chain_ff[FLAG_SYNC_STAGES-2:0], full_w};
      nempty_chain_ff <= {nempty_chain_ff[FLAG_SYNC_STAGES-2:0], rnz};
      ov_chain_ff <= {ov_chain_ff[VALID_STAGES-2:0], ov_ff};
      hf_n_ff <= !hf_hit;
      paf_n_ff <= !paf_hit;
      pae_n_ff <= pae_hit;
    end
  end

  // Pins of the inactive mode rest high
  wire full_late = full_chain_ff[FLAG_SYNC_STAGES-1];
  assign EMPTY_FLAG_N = fall_through_timing_ff || nempty_chain_ff[FLAG_SYNC_STAGES-1];
  assign FULL_FLAG_N = fall_through_timing_ff || !full_late;
  assign OUTPUT_VALID_N = !fall_through_timing_ff || !ov_chain_ff[VALID_STAGES-1];
  assign INPUT_READY_N = !fall_through_timing_ff || full_late;
  assign HALF_FULL_FLAG_N = hf_n_ff;
  assign ALMOST_FULL_FLAG_N = paf_n_ff;
  assign ALMOST_EMPTY_FLAG_N = pae_n_ff;

  // Avalon-MM slave: every access waits exactly one cycle
  logic ack_ff;
  logic [31:0] readdata_ff;

  wire req = AVS_READ || AVS_WRITE;
  wire wr_take = AVS_WRITE && ack_ff;
  wire sel_eo = (AVS_ADDRESS == OFS_EMPTY_OFFSET);
  wire sel_fo = (AVS_ADDRESS == OFS_FULL_OFFSET);
  wire [31:0] eo_new = merge_bytes(32'(empty_off_ff), AVS_WRITEDATA,
                                   AVS_BYTEENABLE);
  wire [31:0] fo_new = merge_bytes(32'(full_off_ff), AVS_WRITEDATA,
                                   AVS_BYTEENABLE);
  // Offsets beyond D-1 would break the thresholds, so they are dropped
  wire eo_ok = (eo_new < 32'(DEPTH));
  wire fo_ok = (fo_new < 32'(DEPTH));
  wire [31:0] status_word = (32'(fall_through_timing_ff) << ST_MODE)
                          | (32'(tot_r == '0) << ST_EMPTY)
                          | (32'(full_w) << ST_FULL)
                          | (32'(hf_hit) << ST_HALF)
                          | (32'(paf_hit) << ST_ALMOST_FULL)
                          | (32'(!pae_hit) << ST_ALMOST_EMPTY);
  wire [31:0] rd_mux = sel_eo ? 32'(empty_off_ff) :
                       sel_fo ? 32'(full_off_ff) :
                       (AVS_ADDRESS == OFS_STATUS) ? status_word :
                       (AVS_ADDRESS == OFS_LEVEL) ? 32'(tot_r) : 32'h0;

  assign AVS_WAITREQUEST = req && !ack_ff;
  assign AVS_READDATA = readdata_ff;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
      readdata_ff <= RST_READDATA;
    end else begin
      ack_ff <= req && !ack_ff;
      if (AVS_READ && !ack_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      empty_off_ff <= AW'(DEF_OFS);
      full_off_ff <= AW'(DEF_OFS);
    end else begin
      if (wr_take && sel_eo && eo_ok) begin
        empty_off_ff <= eo_new[AW-1:0];
      end
      if (wr_take && sel_fo && fo_ok) begin
        full_off_ff <= fo_new[AW-1:0];
      end
    end
  end

  mode_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !init_ff |=> $stable(fall_through_timing_ff))
    else $error("mode changed after it was latched");

  write_count_a: assert property (@(posedge CLK) disable iff (RST)
    (!WRITE_EN_N && !full_w && !init_ff) |=> wbin_ff == $past(wbin_ff) + PW'(1))
    else $error("accepted write did not advance write pointer");

  full_block_a: assert property (@(posedge CLK) disable iff (RST)
    full_w |=> wbin_ff == $past(wbin_ff))
    else $error("write taken while full");

  empty_ignore_a: assert property (@(posedge CLK) disable iff (RST)
    (!fall_through_timing_ff && !rnz) |=> rbin_ff == $past(rbin_ff))
    else $error("read performed while empty");

  fall_through_a: assert property (@(posedge CLK) disable iff (RST)
    (fall_through_timing_ff && rnz && !ov_ff) |=> ov_ff && rbin_ff == $past(rbin_ff) + PW'(1))
    else $error("first word did not fall through");

  valid_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (fall_through_timing_ff && !ov_ff && !rnz) |=> !ov_ff && $stable(READ_DATA_OUT))
    else $error("output changed with nothing stored");

  full_two_stage_a: assert property (@(posedge CLK) disable iff (RST)
    (!fall_through_timing_ff && !init_ff) |-> FULL_FLAG_N == !$past(full_w, 2))
    else $error("full flag not two stages behind");

  valid_three_stage_a: assert property (@(posedge CLK) disable iff (RST)
    fall_through_timing_ff |-> OUTPUT_VALID_N == !$past(ov_ff, 3))
    else $error("output valid not three stages behind");

  half_thresh_a: assert property (@(posedge CLK) disable iff (RST)
    ##1 HALF_FULL_FLAG_N == ($past(tot_w) < $past(hf_thr)))
    else $error("half-full flag wrong for level");

  almost_empty_a: assert property (@(posedge CLK) disable iff (RST)
    ##1 ALMOST_EMPTY_FLAG_N == ($past(tot_r) > CW'($past(empty_off_ff)) + $past(mode_add)))
    else $error("almost-empty flag wrong for level");

  offset_range_a: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && sel_eo && !eo_ok) |=> $stable(empty_off_ff))
    else $error("out of range empty offset stored");

endmodule : dual_mode_fifo

//--- dv/fifo_partner.sv
// Writer and reader logic on the far side of the FIFO's data ports.
// Assumes the bench calls its tasks from one process, all on clk.
module fifo_partner
  import fifo_pkg::*;
(
  // Clock
  input wire logic clk,
  // Toward the FIFO
  output logic write_en_n,
  output logic [DATA_W-1:0] data_in,
  output logic read_en_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    write_en_n = 1'b1;
    data_in = '0;
    read_en_n = 1'b1;
  end

  // One word per call; the idle edge between calls keeps strobes clean
  task automatic push(input logic [DATA_W-1:0] d);
    @(posedge clk);
    write_en_n <= 1'b0;
    data_in <= d;
    @(posedge clk);
    write_en_n <= 1'b1;
    // Lines are not left holding the word, so a late capture shows up
    data_in <= ~d;
  endtask : push

  // Every word is asked for, the first one included
  task automatic pop();
    @(posedge clk);
    read_en_n <= 1'b0;
    @(posedge clk);
    read_en_n <= 1'b1;
  endtask : pop
endmodule : fifo_partner

//--- dv/testbench.sv
// Self-checking bench for the dual-mode FIFO, both timing modes in turn.
// Assumes the FIFO, its partner and the register bus all run on clk.
module testbench
  import fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Small depth keeps every threshold reachable in a short run
  localparam int D = 16;
  localparam int N_OFS = 3;
  localparam int M_OFS = 2;
  typedef struct {logic wr; int cnt;} row_s;
  logic clk, rst, fall_through_select;
  logic write_en_n, read_en_n;
  logic [DATA_W-1:0] data_in, read_data_out;
  logic empty_flag_n, full_flag_n, output_valid_n, input_ready_n;
  logic almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  int num_errors = 0;
  int compares = 0;

  dual_mode_fifo #(.DEPTH(D), .WIDTH(DATA_W)) dual_mode_fifo_i (
    .CLK(clk), .RST(rst), .FALL_THROUGH_SELECT(fall_through_select),
    .WRITE_EN_N(write_en_n), .DATA_IN(data_in),
    .READ_EN_N(read_en_n), .READ_DATA_OUT(read_data_out),
    .EMPTY_FLAG_N(empty_flag_n), .FULL_FLAG_N(full_flag_n),
    .OUTPUT_VALID_N(output_valid_n), .INPUT_READY_N(input_ready_n),
    .ALMOST_EMPTY_FLAG_N(almost_empty_flag_n),
    .ALMOST_FULL_FLAG_N(almost_full_flag_n),
    .HALF_FULL_FLAG_N(half_full_flag_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest)
  );

  fifo_partner fifo_partner_i (
    .clk(clk), .write_en_n(write_en_n), .data_in(data_in),
    .read_en_n(read_en_n)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int t;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // Waitrequest and readdata are read as they stood at this edge
    for (t = 0; t < 20; t++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (t == 20) num_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic check_flags(input logic ft, input int k);
    logic [31:0] lvl;
    check(empty_flag_n, ft | (k > 0));
    check(full_flag_n, ft | (k < D));
    check(output_valid_n, !ft | (k == 0));
    check(input_ready_n, !ft | (k > D));
    check(almost_empty_flag_n, k > N_OFS + ft);
    check(almost_empty_flag_n, k > N_OFS + ft);
    check(half_full_flag_n, k < D / 2 + 1 + ft);
    check(almost_full_flag_n, k < D - M_OFS + ft);
    bus(1'b0, OFS_LEVEL, '0, lvl);
    check(lvl, DATA_W'(k));
  endtask : check_flags

  task automatic do_reset(input logic ft);
    @(posedge clk);
    rst <= 1'b1;
    fall_through_select <= ft;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(empty_flag_n, 1'b0);
    check(full_flag_n & half_full_flag_n & almost_full_flag_n, 1'b1);
    check(output_valid_n & input_ready_n, 1'b1);
    check(almost_empty_flag_n, 1'b0);
    check(read_data_out, '0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic run_mode(input logic ft);
    row_s rows[$];
    logic [DATA_W-1:0] q[$];
    logic [DATA_W-1:0] last, w;
    logic [31:0] rd;
    int cap, i;
    cap = D + ft;
    last = '0;
    do_reset(ft);
    bus(1'b1, OFS_EMPTY_OFFSET, 32'(N_OFS), rd);
    bus(1'b1, OFS_FULL_OFFSET, 32'(M_OFS), rd);
    bus(1'b1, OFS_EMPTY_OFFSET, 32'(D), rd);
    bus(1'b0, OFS_EMPTY_OFFSET, '0, rd);
    check(rd, DATA_W'(N_OFS));
    bus(1'b0, OFS_FULL_OFFSET, '0, rd);
    check(rd, DATA_W'(M_OFS));
    bus(1'b0, 4'h2, '0, rd);
    check(rd, '0);
    // The strap moves after reset; the mode must stay
    fall_through_select <= ~ft;
    bus(1'b0, OFS_STATUS, '0, rd);
    check(rd[ST_MODE], ft);
    // Fill past capacity, then drain with one read too many
    for (i = 0; i <= 2 * cap + 1; i++) begin
      if (i <= cap) rows.push_back('{1'b1, (i < cap) ? i + 1 : cap});
      else rows.push_back('{1'b0, (i < 2 * cap) ? 2 * cap - i : 0});
    end
    foreach (rows[r]) begin
      w = {4'hc, 32'h5a00_0000} + DATA_W'(r);
      if (rows[r].wr) begin
        fifo_partner_i.push(w);
        if (q.size() < cap) q.push_back(w);
        if (r == 0) begin
          repeat (3) @(posedge clk);
          @(negedge clk);
          if (ft) check(read_data_out, w);
          else check(empty_flag_n, 1'b0);
          @(negedge clk);
          if (!ft) check(empty_flag_n, 1'b1);
        end
      end else begin
        fifo_partner_i.pop();
        if (q.size() > 0) last = q.pop_front();
      end
      repeat (12) @(posedge clk);
      @(negedge clk);
      if (ft && q.size() > 0) check(read_data_out, q[0]);
      else if (!ft || !rows[r].wr) check(read_data_out, last);
      check_flags(ft, rows[r].cnt);
    end
  endtask : run_mode

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst = 1'b1;
    fall_through_select = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    run_mode(1'b0);
    run_mode(1'b1);
    wrap_up();
  end

  // Both modes together need under 1300 cycles; this allows about thirty times that
  initial begin
    #4000000;
    num_errors++;
    wrap_up();
  end
endmodule : testbench
